//--- logic/colour_result_pkg.sv
/*
 * Constants for the colour result block: register offsets, field positions,
 * reset values, slave address and compensation weights.
 * Assumes one system clock; the serial host talks through the target module.
 */
// How it works
// - Green result bytes at 0x09 and 0x0A
// - Red result bytes at 0x0B and 0x0C
// - Blue result bytes at 0x0D and 0x0E
// - Sixteen bits, or twelve bits at low resolution
// - Results refresh after every finished conversion
// - All result bytes read zero after reset
// - Double buffered, reads never see half updates
// - Answer only slave address 1000100
// - Offset 0x02 bit 7 coarse, bits 5..0 fine
// - Counts scale with chosen resolution
// - Completion flag high when done, low converting
// - Resolution bit 0 selects 16, 1 selects 12
package colour_result_pkg;
   localparam logic [6:0] SLAVE_ADDR       = 7'h44;
   localparam logic [7:0] OFS_COMP_CFG     = 8'h02;
   localparam logic [7:0] OFS_GREEN_LOW    = 8'h09;
   localparam logic [7:0] OFS_GREEN_HIGH   = 8'h0A;
   localparam logic [7:0] OFS_RED_LOW      = 8'h0B;
   localparam logic [7:0] OFS_RED_HIGH     = 8'h0C;
   localparam logic [7:0] OFS_BLUE_LOW     = 8'h0D;
   localparam logic [7:0] OFS_BLUE_HIGH    = 8'h0E;
   localparam int         COARSE_BIT       = 7;
   localparam int         FINE_MSB         = 5;
   localparam logic [7:0] COMP_CFG_WMASK   = 8'hBF;
   localparam logic [7:0] COMP_CFG_RESET   = 8'h00;
   localparam logic [15:0] RESULT_RESET    = 16'h0000;
   localparam logic [7:0] COARSE_WEIGHT    = 8'h6A;
   localparam int         COMP_SHIFT       = 8;
   localparam int         LOW_RES_SHIFT    = 4;
   localparam logic [7:0] UNMAPPED_READ    = 8'h00;
endpackage : colour_result_pkg

//--- logic/serial_target.sv
/*
 * Byte-level serial bus target: start/stop detection, address match,
 * register pointer with auto increment, byte writes and byte reads.
 * Assumes scl/sda arrive asynchronously and the bus wire is resolved outside.
 */
`timescale 1ns/1ps
module serial_target (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Register side
   output logic            start_pulse,
   output logic [7:0]      reg_ptr,
   output logic            wr_strobe,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data
);
   typedef enum {IDLE, ADDR, ADDR_ACK, REG, REG_ACK, WDATA, SEND, SEND_ACK} tstate_type;

   tstate_type state;
   logic [2:0] scl_pipe;
   logic [2:0] sda_pipe;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] tx;
   logic       acked;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;

   // Bit 0 is the first stage and is only read by bit 1
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_pipe <= 3'h7;
         sda_pipe <= 3'h7;
      end else begin
         scl_pipe <= {scl_pipe[1:0], scl_in};
         sda_pipe <= {sda_pipe[1:0], sda_in};
      end
   end

   assign scl_rise   = scl_pipe[1] & ~scl_pipe[2];
   assign scl_fall   = ~scl_pipe[1] & scl_pipe[2];
   assign start_cond = scl_pipe[1] & sda_pipe[2] & ~sda_pipe[1];
   assign stop_cond  = scl_pipe[1] & ~sda_pipe[2] & sda_pipe[1];
   assign sda_out    = 1'b0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state       <= IDLE;
         bit_cnt     <= 4'h0;
         shift       <= 8'h00;
         tx          <= 8'h00;
         acked       <= 1'b0;
         sda_oe      <= 1'b0;
         reg_ptr     <= 8'h00;
         wr_strobe   <= 1'b0;
         wr_data     <= 8'h00;
         start_pulse <= 1'b0;
      end else begin
         wr_strobe   <= 1'b0;
         start_pulse <= 1'b0;
         // Pointer steps only after the strobe, so a write lands at its own offset
         if (wr_strobe) begin
            reg_ptr <= reg_ptr + 8'h01;
         end
         if (start_cond) begin
            state       <= ADDR;
            bit_cnt     <= 4'h0;
            sda_oe      <= 1'b0;
            start_pulse <= 1'b1;
         end else if (stop_cond) begin
            state  <= IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               ADDR, REG, WDATA: begin
                  if (scl_rise) begin
                     shift   <= {shift[6:0], sda_pipe[1]};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     bit_cnt <= 4'h0;
                     if (state == ADDR) begin
                        // Any other address leaves the bus untouched until the next start
                        if (shift[7:1] == colour_result_pkg::SLAVE_ADDR) begin
                           sda_oe <= 1'b1;
                           acked  <= shift[0];
                           state  <= ADDR_ACK;
                        end else begin
                           state <= IDLE;
                        end
                     end else if (state == REG) begin
                        reg_ptr <= shift;
                        sda_oe  <= 1'b1;
                        state   <= REG_ACK;
                     end else begin
                        wr_data   <= shift;
                        wr_strobe <= 1'b1;
                        sda_oe    <= 1'b1;
                        state     <= REG_ACK;
                     end
                  end
               end
               ADDR_ACK: begin
                  if (scl_fall) begin
                     if (acked) begin
                        tx     <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state  <= SEND;
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= REG;
                     end
                  end
               end
               REG_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state  <= WDATA;
                  end
               end
               SEND: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        sda_oe  <= 1'b0;
                        state   <= SEND_ACK;
                     end else begin
                        tx     <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                     end
                  end
               end
               SEND_ACK: begin
                  if (scl_rise) begin
                     acked <= ~sda_pipe[1];
                     if (!sda_pipe[1]) begin
                        reg_ptr <= reg_ptr + 8'h01;
                     end
                  end else if (scl_fall) begin
                     if (acked) begin
                        tx     <= rd_data;
                        sda_oe <= ~rd_data[7];
                        state  <= SEND;
                     end else begin
                        state <= IDLE;
                     end
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : serial_target

//--- logic/colour_result_regs.sv
/*
 * Colour result registers: compensation, resolution trim, live capture,
 * read snapshot, completion flag and the register read/write map.
 * Assumes the front end delivers raw counts with a one-cycle done pulse on
 * sys_clk, and the serial pins arrive from outside the clock domain.
 */
`timescale 1ns/1ps
module colour_result_regs (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Serial bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // Front end results
   input  wire logic        conv_start,
   input  wire logic        conv_done,
   input  wire logic [15:0] raw_green,
   input  wire logic [15:0] raw_red,
   input  wire logic [15:0] raw_blue,
   input  wire logic [15:0] raw_ir,
   input  wire logic        resolution_select,
   // Status and settings toward the front end
   output logic             conversion_complete_flag,
   output logic             ir_coarse_comp_bit,
   output logic [5:0]       ir_fine_comp_field
);
   logic [7:0]  comp_cfg;
   logic [15:0] live_green;
   logic [15:0] live_red;
   logic [15:0] live_blue;
   logic [15:0] snap_green;
   logic [15:0] snap_red;
   logic [15:0] snap_blue;
   logic        start_pulse;
   logic [7:0]  reg_ptr;
   logic        wr_strobe;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;

   // Subtracts the weighted infrared share, floored at zero
   function automatic logic [15:0] compensate(input logic [15:0] raw,
                                              input logic [15:0] ir,
                                              input logic [7:0]  cfg);
      logic [7:0]  weight;
      logic [23:0] product;
      logic [15:0] share;
      weight  = (cfg[colour_result_pkg::COARSE_BIT] ? colour_result_pkg::COARSE_WEIGHT : 8'h00)
                + {2'b00, cfg[colour_result_pkg::FINE_MSB:0]};
      product = ir * weight;
      share   = product[23:colour_result_pkg::COMP_SHIFT];
      compensate = (raw > share) ? raw - share : 16'h0000;
   endfunction : compensate

   // Trims a count to the selected resolution
   function automatic logic [15:0] trim(input logic [15:0] value, input logic low_res);
      logic [15:0] shifted;
      shifted = value >> colour_result_pkg::LOW_RES_SHIFT;
      // High nibble is forced clear at twelve bits
      trim = low_res ? {4'h0, shifted[11:0]} : value;
   endfunction : trim

   serial_target target (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_out     (sda_out),
      .sda_oe      (sda_oe),
      .start_pulse (start_pulse),
      .reg_ptr     (reg_ptr),
      .wr_strobe   (wr_strobe),
      .wr_data     (wr_data),
      .rd_data     (rd_data)
   );

   // Compensation setting, the only writable byte here
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         comp_cfg <= colour_result_pkg::COMP_CFG_RESET;
      end else if (wr_strobe && reg_ptr == colour_result_pkg::OFS_COMP_CFG) begin
         comp_cfg <= wr_data & colour_result_pkg::COMP_CFG_WMASK;
      end
   end

   assign ir_coarse_comp_bit = comp_cfg[colour_result_pkg::COARSE_BIT];
   assign ir_fine_comp_field = comp_cfg[colour_result_pkg::FINE_MSB:0];

   // Live buffer takes each finished conversion whole
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         live_green <= colour_result_pkg::RESULT_RESET;
         live_red   <= colour_result_pkg::RESULT_RESET;
         live_blue  <= colour_result_pkg::RESULT_RESET;
      end else if (conv_done) begin
         live_green <= trim(compensate(raw_green, raw_ir, comp_cfg), resolution_select);
         live_red   <= trim(compensate(raw_red, raw_ir, comp_cfg), resolution_select);
         live_blue  <= trim(compensate(raw_blue, raw_ir, comp_cfg), resolution_select);
      end
   end

   // Snapshot frozen at each start so a burst never mixes two conversions
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         snap_green <= colour_result_pkg::RESULT_RESET;
         snap_red   <= colour_result_pkg::RESULT_RESET;
         snap_blue  <= colour_result_pkg::RESULT_RESET;
      end else if (start_pulse) begin
         snap_green <= live_green;
         snap_red   <= live_red;
         snap_blue  <= live_blue;
      end
   end

   // Done wins over a start arriving in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conversion_complete_flag <= 1'b0;
      end else if (conv_done) begin
         conversion_complete_flag <= 1'b1;
      end else if (conv_start) begin
         conversion_complete_flag <= 1'b0;
      end
   end

   always_comb begin
      case (reg_ptr)
         colour_result_pkg::OFS_COMP_CFG:   rd_data = comp_cfg;
         colour_result_pkg::OFS_GREEN_LOW:  rd_data = snap_green[7:0];
         colour_result_pkg::OFS_GREEN_HIGH: rd_data = snap_green[15:8];
         colour_result_pkg::OFS_RED_LOW:    rd_data = snap_red[7:0];
         colour_result_pkg::OFS_RED_HIGH:   rd_data = snap_red[15:8];
         colour_result_pkg::OFS_BLUE_LOW:   rd_data = snap_blue[7:0];
         colour_result_pkg::OFS_BLUE_HIGH:  rd_data = snap_blue[15:8];
         default:                           rd_data = colour_result_pkg::UNMAPPED_READ;
      endcase
   end
endmodule : colour_result_regs

//--- tb/colour_result_regs_assertions.sv
/* Port assertions for the colour result register block.
   Assumes one clock domain and an open-drain data wire resolved by the bench. */
`timescale 1ns/1ps
module colour_result_checker (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Serial pins
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   // Conversion and settings
   input wire logic       conv_start,
   input wire logic       conv_done,
   input wire logic       conversion_complete_flag,
   input wire logic       ir_coarse_comp_bit,
   input wire logic [5:0] ir_fine_comp_field
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic [6:0] comp = {ir_coarse_comp_bit, ir_fine_comp_field};

   a_flag_on_done: assert property (conv_done |=> conversion_complete_flag)
      else $error("flag not set after done");
   a_flag_start_clear: assert property (conv_start && !conv_done |=> !conversion_complete_flag)
      else $error("flag not cleared by start");
   a_flag_holds: assert property (!conv_start && !conv_done |=> $stable(conversion_complete_flag))
      else $error("flag moved without cause");
   a_flag_rise_cause: assert property ($rose(conversion_complete_flag) |-> $past(conv_done))
      else $error("flag rose without done");
   a_pin_low_only: assert property (sda_out == 1'b0)
      else $error("data pin drives high");
   a_reset_clears: assert property (disable iff (1'b0) rst |=> !conversion_complete_flag && !sda_oe && comp == 7'h00)
      else $error("reset left state set");
   a_comp_idle_stable: assert property ((scl_in && sda_in) [*8] |=> $stable(comp))
      else $error("setting changed on idle bus");
   a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data drive changed with clock high");

   c_done: cover property (conv_done ##1 conversion_complete_flag);
   c_ack: cover property ($rose(sda_oe));
   c_setting: cover property ($changed(comp));
endmodule : colour_result_checker

bind colour_result_regs colour_result_checker u_checker (.sys_clk, .rst, .scl_in, .sda_in,
   .sda_out, .sda_oe, .conv_start, .conv_done, .conversion_complete_flag,
   .ir_coarse_comp_bit, .ir_fine_comp_field);

//--- tb/serial_host_model.sv
/* Serial bus host that writes and burst-reads the result block's registers.
   Assumes a pulled-up open-drain data wire resolved by the bench. */
`timescale 1ns/1ps
module serial_host_model (
   // Clock
   input  wire logic sys_clk,
   // Bus wires
   input  wire logic sda_wire,
   output logic      scl,
   output logic      host_pull
);
   initial begin
      scl = 1'b1;
      host_pull = 1'b0;
   end
   // Eight-cycle half periods leave room for the two-flop synchroniser delay
   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_clk
   task automatic start_cond;
      host_pull = 1'b0;
      wait_clk(4);
      scl = 1'b1;
      wait_clk(8);
      host_pull = 1'b1;
      wait_clk(8);
      scl = 1'b0;
      wait_clk(4);
   endtask : start_cond
   task automatic stop_cond;
      host_pull = 1'b1;
      wait_clk(4);
      scl = 1'b1;
      wait_clk(8);
      host_pull = 1'b0;
      wait_clk(8);
   endtask : stop_cond
   task automatic bit_io(input logic b, output logic r);
      host_pull = ~b;
      wait_clk(4);
      scl = 1'b1;
      wait_clk(8);
      r = sda_wire;
      scl = 1'b0;
      wait_clk(4);
   endtask : bit_io
   task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                          output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack);
   endtask : byte_io
   // No read count writes one byte d; otherwise n bytes are read, low offset first
   task automatic xfer(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                       input int n, output logic [47:0] v, output logic ok);
      logic [7:0] rx;
      logic       ak;
      v = '0;
      start_cond;
      byte_io({a, 1'b0}, 1'b1, rx, ak);
      ok = ~ak;
      byte_io(ofs, 1'b1, rx, ak);
      ok &= ~ak;
      if (n == 0) begin
         byte_io(d, 1'b1, rx, ak);
         ok &= ~ak;
      end else begin
         start_cond;
         byte_io({a, 1'b1}, 1'b1, rx, ak);
         ok &= ~ak;
         for (int i = 0; i < n; i++) begin
            byte_io(8'hFF, i == n - 1, rx, ak);
            v[i*8 +: 8] = rx;
         end
      end
      stop_cond;
   endtask : xfer
endmodule : serial_host_model

//--- tb/test_rgb_result_data_registers.sv
/* Self-checking bench for the colour result registers.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
module test_rgb_result_data_registers;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        conv_start = 1'b0;
   logic        conv_done = 1'b0;
   logic [15:0] raw_green = 16'h0000;
   logic [15:0] raw_red = 16'h0000;
   logic [15:0] raw_blue = 16'h0000;
   logic [15:0] raw_ir = 16'h0000;
   logic        resolution_select = 1'b0;
   logic        sda_out, sda_oe, flag, coarse, scl, host_pull, ok;
   logic [5:0]  fine;
   logic [31:0] lfsr = 32'h48173504;
   logic [7:0]  cfg = 8'h00;
   logic [47:0] v, e, e2;
   int          bad_count = 0;
   int          total_checks = 0;
   wire logic   sda_wire = ~((sda_oe & ~sda_out) | host_pull);

   colour_result_regs dut (.sys_clk, .rst, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
      .conv_start, .conv_done, .raw_green, .raw_red, .raw_blue, .raw_ir, .resolution_select,
      .conversion_complete_flag(flag), .ir_coarse_comp_bit(coarse), .ir_fine_comp_field(fine));
   serial_host_model host (.sys_clk, .sda_wire, .scl, .host_pull);

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand
   function automatic logic [15:0] count(input int raw, input int ir, input logic res);
      int r;
      r = raw - ((ir * (106 * cfg[7] + cfg[5:0])) >> 8);
      if (r < 0) r = 0;
      if (res) r = r >> 4;
      return r[15:0];
   endfunction : count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic convert(input logic res, output logic [47:0] x);
      lfsr = next_rand(lfsr);
      raw_green = lfsr[15:0];
      raw_red = lfsr[31:16];
      lfsr = next_rand(lfsr);
      raw_blue = lfsr[15:0];
      raw_ir = {4'h0, lfsr[27:16]};
      resolution_select = res;
      conv_start = 1'b1;
      tick(1);
      conv_start = 1'b0;
      chk(flag, 1'b0);
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
      chk(flag, 1'b1);
      x = {count(raw_blue, raw_ir, res), count(raw_red, raw_ir, res), count(raw_green, raw_ir, res)};
   endtask : convert

   initial begin
      repeat (100000) @(posedge sys_clk);
      bad_count++;
      end_sim;
   end
   initial begin
      tick(16);
      rst = 1'b0;
      chk({flag, coarse, fine}, 8'h00);
      host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_GREEN_LOW, 8'h00, 6, v, ok);
      chk({ok, v}, {1'b1, 48'h0});
      for (int k = 0; k < 4; k++) begin
         lfsr = next_rand(lfsr);
         cfg = (k == 3) ? 8'hFF : lfsr[7:0];
         host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_COMP_CFG, cfg, 0, v, ok);
         chk({ok, coarse, fine}, {1'b1, cfg[7], cfg[5:0]});
         host.xfer(7'h45, colour_result_pkg::OFS_COMP_CFG, ~cfg, 0, v, ok);
         chk({ok, coarse, fine}, {1'b0, cfg[7], cfg[5:0]});
         host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_COMP_CFG, 8'h00, 1, v, ok);
         chk(v, cfg & 8'hBF);
         convert(k[0], e);
         host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_GREEN_LOW, 8'h00, 6, v, ok);
         chk({ok, v}, {1'b1, e});
      end
      // A conversion landing mid-burst must not tear the snapshot
      fork
         host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_GREEN_LOW, 8'h00, 6, v, ok);
         begin
            tick(600);
            convert(1'b0, e2);
         end
      join
      chk({ok, v}, {1'b1, e});
      host.xfer(colour_result_pkg::SLAVE_ADDR, colour_result_pkg::OFS_GREEN_LOW, 8'h00, 6, v, ok);
      chk(v, e2);
      host.xfer(colour_result_pkg::SLAVE_ADDR, 8'h20, 8'h00, 1, v, ok);
      chk({ok, v}, {1'b1, 48'h0});
      end_sim;
   end
endmodule : test_rgb_result_data_registers
